// [cdr_config_decode_reset_seq.sv]
// cdr_config_decode_reset_seq: decodes the four configuration bytes and
// sequences release of the internal reset after power-on, resume or brown-out.
// assumes configuration bytes are stable while read; analog inputs are
// already synchronous to core_clk; rst_n acts as the power-on reset.
//
// What this block does
// - clock switch mode gates switching and monitor
// - lock-once bit allows single pin reconfiguration
// - oscillator pin clock out or gpio, non-crystal
// - primary oscillator mode decodes four modes
// - fuse enable keeps watchdog on permanently
// - without fuse, software bit controls watchdog
// - window disable bit selects non-window mode
// - prescale bit selects 1:128 or 1:32
// - postscale ratio is two to field
// - i2c routed to primary or alternate pins
// - power-up delay doubles per code, 000 off
// - debug channel code picks pin pair
// - regulator start-up blocks execution after power-up
// - brown-out produces whole-device reset pulse
// - brown-out picks clock from configuration fields
// - oscillator start-up timer holds system clock
// - pll use holds clock until lock
// - power-up delay parallel; crystal fallback fixed delay
// - brown-out sets status flag for software
// - brown-out detection active in sleep, idle
`timescale 1ns/1ps

module cdr_config_decode_reset_seq #(
  parameter int POWERUP_TIMER_STEP_CYC = cdr_pkg::POWERUP_TIMER_BASE_CYC, // 2 ms step
  parameter int OST_CYC = cdr_pkg::OSC_STARTUP_CYC // oscillator start-up
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] oscillator_config,
  input wire logic [7:0] watchdog_config,
  input wire logic [7:0] poweron_config,
  input wire logic [7:0] debug_config,
  input wire logic [2:0] initial_osc_select,
  input wire logic brownout_det,
  input wire logic power_down,
  input wire logic pll_lock,
  input wire logic soft_wr,
  input wire logic soft_wdata,
  input wire logic bor_flag_clr,
  input wire logic pps_cfg_write,
  output cdr_pkg::cdr_cfg_t cfg,
  output logic watchdog_enable,
  output logic low_power_rc_enable,
  output logic watchdog_soft_enable,
  output logic bor_flag,
  output logic bor_reset_pulse,
  output logic internal_reset_n,
  output logic exec_enable,
  output logic sys_clk_hold,
  output logic [2:0] clk_src,
  output logic pps_write_ok
);

  // sequencer state and its shared delay counter
  cdr_pkg::cdr_state_t state;
  cdr_pkg::cdr_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [2:0] next_clk_src;
  // reset control register bits and pin-select bookkeeping
  logic next_watchdog_soft_enable;
  logic next_bor_flag;
  logic bor_prev;
  logic next_bor_reset_pulse;
  logic pps_done;
  logic next_pps_done;
  cdr_pkg::cdr_cfg_t next_cfg;
  // derived terms
  logic [1:0] pmode;
  logic [1:0] cksm;
  logic [1:0] dbg_ch;
  logic [2:0] powerup_timer_sel;
  logic crystal;
  logic osc_used;
  logic pll_used;
  logic [31:0] pwr_cyc;
  logic [31:0] ost_need;
  logic wait_done;
  logic bor_event;
  logic fuse_en;

  // field extraction and the timing targets of the wait state
  always_comb
  begin
    pmode = oscillator_config[cdr_pkg::OSC_PMODE_HI:cdr_pkg::OSC_PMODE_LO];
    cksm = oscillator_config[cdr_pkg::OSC_CKSM_HI:cdr_pkg::OSC_CKSM_LO];
    dbg_ch = debug_config[cdr_pkg::DBG_CH_HI:cdr_pkg::DBG_CH_LO];
    powerup_timer_sel = poweron_config[cdr_pkg::POR_POWERUP_TIMER_HI:cdr_pkg::POR_POWERUP_TIMER_LO];
    fuse_en = watchdog_config[cdr_pkg::WDT_FUSE_EN];
    crystal = (pmode == cdr_pkg::PMODE_HS) || (pmode == cdr_pkg::PMODE_XT);
    // oscillator mode in use only when primary is chosen and enabled
    osc_used = ((clk_src == cdr_pkg::IOSC_PRI) || (clk_src == cdr_pkg::IOSC_PRI_PLL))
      && (pmode != cdr_pkg::PMODE_OFF);
    pll_used = (clk_src == cdr_pkg::IOSC_FRC_PLL) || (clk_src == cdr_pkg::IOSC_PRI_PLL);
    // delay doubles per code; code 000 falls back to fixed delay on crystal
    if (powerup_timer_sel == 3'h0)
    begin
      pwr_cyc = crystal ? 32'(cdr_pkg::FAIL_SAFE_CYC) : 32'h0;
    end
    else
    begin
      pwr_cyc = 32'(POWERUP_TIMER_STEP_CYC) << (powerup_timer_sel - 3'h1);
    end
    ost_need = osc_used ? 32'(OST_CYC) : 32'h0;
    // both delays run in parallel off one counter
    wait_done = (cnt >= pwr_cyc) && (cnt >= ost_need);
    bor_event = brownout_det && !bor_prev;
  end

  // sequencer next state: regulator wait, oscillator wait, pll wait, run
  always_comb
  begin
    next_state = state;
    next_cnt = (cnt == 32'hffffffff) ? cnt : cnt + 32'h1;
    next_clk_src = clk_src;
    case (state)
      cdr_pkg::CDR_REG_WAIT:
      begin
        // clock source is picked while the device is still held
        next_clk_src = initial_osc_select;
        if (cnt >= 32'(cdr_pkg::REG_STARTUP_CYC - 1))
        begin
          next_state = cdr_pkg::CDR_OSC_WAIT;
          next_cnt = 32'h0;
        end
      end
      cdr_pkg::CDR_OSC_WAIT:
      begin
        if (wait_done)
        begin
          next_state = pll_used ? cdr_pkg::CDR_PLL_WAIT : cdr_pkg::CDR_RUN;
        end
      end
      cdr_pkg::CDR_PLL_WAIT:
      begin
        if (pll_lock)
        begin
          next_state = cdr_pkg::CDR_RUN;
        end
      end
      default:
      begin
        // running: counter is idle
        next_cnt = cnt;
      end
    endcase
    // brown-out or power-down restarts the whole sequence, sleep or not
    if (brownout_det || power_down)
    begin
      next_state = cdr_pkg::CDR_REG_WAIT;
      next_cnt = 32'h0;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= cdr_pkg::CDR_REG_WAIT;
      cnt <= 32'h0;
      clk_src <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      clk_src <= next_clk_src;
    end
  end

  // reset release comes straight from state; clock hold from state and counter
  always_comb
  begin
    internal_reset_n = (state == cdr_pkg::CDR_RUN);
    exec_enable = (state == cdr_pkg::CDR_RUN);
    // clock held through regulator wait, start-up timer and pll wait
    sys_clk_hold = (state == cdr_pkg::CDR_REG_WAIT)
      || ((state == cdr_pkg::CDR_OSC_WAIT) && (cnt < ost_need))
      || (state == cdr_pkg::CDR_PLL_WAIT);
  end

  // reset control bits, brown-out pulse and pin-select lock next values
  always_comb
  begin
    next_watchdog_soft_enable = watchdog_soft_enable;
    // clearing writes are ignored while the fuse forces the watchdog on
    if (soft_wr && (soft_wdata || !fuse_en))
    begin
      next_watchdog_soft_enable = soft_wdata;
    end
    if (state != cdr_pkg::CDR_RUN)
    begin
      next_watchdog_soft_enable = 1'b0;
    end
    // set beats a clear in the same cycle
    next_bor_flag = bor_event ? 1'b1 : (bor_flag_clr ? 1'b0 : bor_flag);
    next_bor_reset_pulse = bor_event;
    next_pps_done = pps_done;
    if (pps_cfg_write && pps_write_ok)
    begin
      next_pps_done = 1'b1;
    end
    if (state != cdr_pkg::CDR_RUN)
    begin
      next_pps_done = 1'b0;
    end
  end

  // reset control registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      watchdog_soft_enable <= 1'b0;
      bor_flag <= 1'b0;
      bor_prev <= 1'b0;
      bor_reset_pulse <= 1'b0;
      pps_done <= 1'b0;
    end
    else
    begin
      watchdog_soft_enable <= next_watchdog_soft_enable;
      bor_flag <= next_bor_flag;
      bor_prev <= brownout_det;
      bor_reset_pulse <= next_bor_reset_pulse;
      pps_done <= next_pps_done;
    end
  end

  // watchdog gating and pin-select permission
  always_comb
  begin
    watchdog_enable = fuse_en || watchdog_soft_enable;
    low_power_rc_enable = watchdog_enable;
    // lock-once permits one write after each reset, otherwise any number
    pps_write_ok = !(cfg.pin_select_lock_once && pps_done);
  end

  // configuration decode
  always_comb
  begin
    next_cfg = '0;
    next_cfg.clk_switch_en = !cksm[1];
    next_cfg.fail_safe_en = (cksm == 2'h0);
    next_cfg.pin_select_lock_once = oscillator_config[cdr_pkg::OSC_PPS_ONCE];
    // crystal modes own the pin, so neither use applies there
    next_cfg.oscillator_out_pin_clock_out = !crystal && oscillator_config[cdr_pkg::OSC_OSCILLATOR_OUT_PIN_FN];
    next_cfg.oscillator_out_pin_gpio = !crystal && !oscillator_config[cdr_pkg::OSC_OSCILLATOR_OUT_PIN_FN];
    next_cfg.posc_disabled = (pmode == cdr_pkg::PMODE_OFF);
    next_cfg.posc_hs = (pmode == cdr_pkg::PMODE_HS);
    next_cfg.posc_xt = (pmode == cdr_pkg::PMODE_XT);
    next_cfg.posc_ec = (pmode == cdr_pkg::PMODE_EC);
    next_cfg.wdt_window_en = !watchdog_config[cdr_pkg::WDT_WIN_DIS];
    next_cfg.wdt_prescale_div = watchdog_config[cdr_pkg::WDT_PRE_SEL]
      ? cdr_pkg::WDT_PRE_128 : cdr_pkg::WDT_PRE_32;
    next_cfg.wdt_postscale_div = 16'h1
      << watchdog_config[cdr_pkg::WDT_POST_HI:cdr_pkg::WDT_POST_LO];
    next_cfg.i2c_primary = poweron_config[cdr_pkg::POR_I2C_ALT];
    next_cfg.i2c_alternate = !poweron_config[cdr_pkg::POR_I2C_ALT];
    case (dbg_ch)
      2'h3: next_cfg.debug_pair = 3'h1;
      2'h2: next_cfg.debug_pair = 3'h2;
      2'h1: next_cfg.debug_pair = 3'h4;
      default: next_cfg.debug_pair = 3'h0;
    endcase
  end

  // decoded configuration register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg <= '0;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // monitor never runs without switching
  property p_cksm;
    cfg.fail_safe_en |-> cfg.clk_switch_en;
  endproperty
  a_cksm: assert property (p_cksm) else $error("monitor on without switching");

  // exactly one oscillator mode decoded
  property p_pmode;
    $past(rst_n) |-> $onehot({cfg.posc_disabled, cfg.posc_hs, cfg.posc_xt, cfg.posc_ec});
  endproperty
  a_pmode: assert property (p_pmode) else $error("oscillator mode not one-hot");

  // fuse keeps watchdog on despite a clearing write
  property p_fuse;
    fuse_en && soft_wr && !soft_wdata && watchdog_soft_enable && state == cdr_pkg::CDR_RUN
      |=> watchdog_soft_enable && watchdog_enable && low_power_rc_enable;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse failed to hold watchdog");

  // postscale ratio follows the field a cycle later
  property p_post;
    $past(rst_n) |-> cfg.wdt_postscale_div == (16'h1 << $past(watchdog_config[3:0]));
  endproperty
  a_post: assert property (p_post) else $error("postscale ratio wrong");

  // brown-out pulls reset next cycle and sets the flag
  property p_bor;
    $rose(brownout_det) |=> !internal_reset_n && bor_flag ##0 bor_reset_pulse;
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out not handled");

  // set wins over a clear in the same cycle
  property p_bor_flag;
    bor_event && bor_flag_clr |=> bor_flag;
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out flag lost");

  // pll wait keeps clock held until lock is seen
  property p_pll;
    state == cdr_pkg::CDR_PLL_WAIT && !pll_lock && !brownout_det && !power_down
      |=> state == cdr_pkg::CDR_PLL_WAIT && sys_clk_hold && !internal_reset_n;
  endproperty
  a_pll: assert property (p_pll) else $error("released before pll lock");

  // execution stays blocked for at least 8 cycles after it drops
  property p_reg;
    $fell(exec_enable) |-> !exec_enable [*8];
  endproperty
  a_reg: assert property (p_reg) else $error("execution resumed too soon");

  // release only once both parallel delays have elapsed
  property p_release;
    state == cdr_pkg::CDR_OSC_WAIT && next_state != cdr_pkg::CDR_OSC_WAIT
      && !brownout_det && !power_down |-> cnt >= pwr_cyc && cnt >= ost_need;
  endproperty
  a_release: assert property (p_release) else $error("released before delays");

  // reserved debug code selects no pair
  property p_dbg;
    $past(dbg_ch) == 2'h0 && $past(rst_n) |-> cfg.debug_pair == 3'h0;
  endproperty
  a_dbg: assert property (p_dbg) else $error("reserved debug code picked pair");

endmodule // cdr_config_decode_reset_seq

// [cdr_pkg.sv]
// cdr_pkg: field layout, timing constants, states and the decoded
// configuration carrier shared by the configuration decode and reset sequencer.
// assumes a 25 MHz core clock; all timing counts but the oscillator start-up one derive from it here.
package cdr_pkg;

  // core clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ = 25;

  // oscillator configuration byte: field positions
  localparam int OSC_CKSM_HI = 7; // clock switch mode, upper bit
  localparam int OSC_CKSM_LO = 6; // clock switch mode, lower bit
  localparam int OSC_PPS_ONCE = 5; // pin-select lock once
  localparam int OSC_OSCILLATOR_OUT_PIN_FN = 2; // oscillator out pin function
  localparam int OSC_PMODE_HI = 1; // primary oscillator mode, upper bit
  localparam int OSC_PMODE_LO = 0; // primary oscillator mode, lower bit

  // watchdog configuration byte: field positions
  localparam int WDT_FUSE_EN = 7; // watchdog fuse enable
  localparam int WDT_WIN_DIS = 6; // window disable
  localparam int WDT_PRE_SEL = 4; // prescale select
  localparam int WDT_POST_HI = 3; // postscale field, upper bit
  localparam int WDT_POST_LO = 0; // postscale field, lower bit

  // power-on configuration byte: field positions
  localparam int POR_I2C_ALT = 5; // i2c pin select
  localparam int POR_POWERUP_TIMER_HI = 2; // power-up timer select, upper bit
  localparam int POR_POWERUP_TIMER_LO = 0; // power-up timer select, lower bit

  // debug configuration byte: field positions
  localparam int DBG_CH_HI = 1; // debug channel, upper bit
  localparam int DBG_CH_LO = 0; // debug channel, lower bit

  // primary oscillator mode codes
  localparam logic [1:0] PMODE_OFF = 2'h3; // primary oscillator disabled
  localparam logic [1:0] PMODE_HS = 2'h2; // crystal, high speed
  localparam logic [1:0] PMODE_XT = 2'h1; // crystal, medium
  localparam logic [1:0] PMODE_EC = 2'h0; // external clock input

  // initial oscillator select codes that matter to the sequencer
  localparam logic [2:0] IOSC_FRC_PLL = 3'h1; // internal rc with pll
  localparam logic [2:0] IOSC_PRI = 3'h2; // primary oscillator
  localparam logic [2:0] IOSC_PRI_PLL = 3'h3; // primary oscillator with pll

  // watchdog prescale ratios
  localparam logic [7:0] WDT_PRE_128 = 8'h80;
  localparam logic [7:0] WDT_PRE_32 = 8'h20;

  // regulator start-up time, then its cycle count (least time, rounded up)
  localparam int REG_STARTUP_NS = 20000;
  localparam int REG_STARTUP_CYC = (REG_STARTUP_NS * CLK_MHZ + 999) / 1000;

  // power-up timer base step (code 001), default for the module parameter
  localparam int POWERUP_TIMER_BASE_MS = 2;
  localparam int POWERUP_TIMER_BASE_CYC = POWERUP_TIMER_BASE_MS * CLK_MHZ * 1000;

  // fixed delay used with a crystal when the power-up timer is off
  localparam int FAIL_SAFE_DELAY_US = 100;
  localparam int FAIL_SAFE_CYC = FAIL_SAFE_DELAY_US * CLK_MHZ;

  // oscillator start-up timer default length in core cycles
  localparam int OSC_STARTUP_CYC = 1024;

  // reset sequencer states, gray coded along the path
  typedef enum logic [1:0] {
    CDR_REG_WAIT = 2'b00, // regulator start-up
    CDR_OSC_WAIT = 2'b01, // oscillator start-up and power-up timer
    CDR_PLL_WAIT = 2'b11, // waiting for pll lock
    CDR_RUN = 2'b10 // internal reset released
  } cdr_state_t;

  // decoded configuration carried to the rest of the chip
  typedef struct packed {
    logic clk_switch_en; // clock switching allowed
    logic fail_safe_en; // fail-safe clock monitor on
    logic pin_select_lock_once; // only one pin-select reconfiguration
    logic oscillator_out_pin_clock_out; // oscillator out pin drives clock
    logic oscillator_out_pin_gpio; // oscillator out pin is digital i/o
    logic posc_disabled; // primary oscillator off
    logic posc_hs; // crystal high speed mode
    logic posc_xt; // crystal medium mode
    logic posc_ec; // external clock mode
    logic wdt_window_en; // windowed watchdog
    logic [7:0] wdt_prescale_div; // prescaler ratio
    logic [15:0] wdt_postscale_div; // postscaler ratio
    logic i2c_primary; // i2c on primary pins
    logic i2c_alternate; // i2c on alternate pins
    logic [2:0] debug_pair; // one-hot pair 1..3, zero for none
  } cdr_cfg_t;

endpackage

// [cdr_supply_cfg_model.sv]
// cdr_supply_cfg_model: configuration memory and supply monitor stand-in
// assumes the bench changes its requests just after rising edges
`timescale 1ns/1ps

module cdr_supply_cfg_model #(
  parameter int LOCK_DLY = 5 // pll lock latency, arbitrary
) (
  input wire logic core_clk,
  input wire logic [31:0] cfg_req,
  input wire logic allow_rsv,
  input wire logic bor_req,
  input wire logic pd_req,
  input wire logic lock_en,
  output logic [7:0] osc_byte = 8'h00,
  output logic [7:0] wdt_byte = 8'h00,
  output logic [7:0] por_byte = 8'h00,
  output logic [7:0] dbg_byte = 8'h03,
  output logic brownout_det = 1'b0,
  output logic power_down = 1'b0,
  output logic pll_lock = 1'b0
);
  int lock_cnt = 0; // cycles since the pll was asked to lock

  // bytes and analog levels; the reserved channel code is replaced unless allow_rsv is set
  always @(posedge core_clk)
  begin
    osc_byte <= cfg_req[31:24];
    wdt_byte <= cfg_req[23:16];
    por_byte <= cfg_req[15:8];
    dbg_byte <= (cfg_req[1:0] == 2'h0 && !allow_rsv) ? 8'h03 : cfg_req[7:0];
    brownout_det <= bor_req;
    power_down <= pd_req;
    lock_cnt <= lock_en ? lock_cnt + 1 : 0;
    pll_lock <= lock_en && lock_cnt >= LOCK_DLY;
  end
endmodule // cdr_supply_cfg_model

// [test_config_decode_reset_seq.sv]
// test_config_decode_reset_seq: sequences of reset, brown-out and decode checks
// assumes a 25 MHz clock and shortened power-up and start-up counts
`timescale 1ns/1ps

module test_config_decode_reset_seq;
  localparam int STEP = 20; // shortened power-up step
  localparam int OSC_STARTUP_TIMER = 16; // shortened start-up timer
  localparam int LOCK = 5; // model pll latency
  localparam int REG = cdr_pkg::REG_STARTUP_CYC;
  localparam int FS = cdr_pkg::FAIL_SAFE_CYC;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] cfg_req = 32'hc0000303; // osc, watchdog, power-on, debug bytes
  logic [2:0] iosc = 3'h0;
  logic allow_rsv = 1'b0;
  logic bor_req = 1'b0;
  logic pd_req = 1'b0;
  logic lock_en = 1'b0;
  logic soft_wr = 1'b0;
  logic soft_wdata = 1'b0;
  logic bor_flag_clr = 1'b0;
  logic pps_cfg_write = 1'b0;
  logic [7:0] osc_b, wdt_b, por_b, dbg_b;
  logic bdet, pdn, lock;
  cdr_pkg::cdr_cfg_t cfg;
  cdr_pkg::cdr_cfg_t e; // expected decode
  logic wd_en, low_power_rc_osc_en, soft_en, bor_flag, bor_pulse, irst_n, exec_en, clk_hold, pps_ok;
  logic [2:0] clk_src;
  logic xtal;
  int error_cnt = 0;
  int comparisons = 0;

  // 40 ns clock
  always #20 core_clk = ~core_clk;

  cdr_supply_cfg_model #(.LOCK_DLY(LOCK)) mem (.core_clk(core_clk), .cfg_req(cfg_req),
    .allow_rsv(allow_rsv), .bor_req(bor_req), .pd_req(pd_req), .lock_en(lock_en),
    .osc_byte(osc_b), .wdt_byte(wdt_b), .por_byte(por_b), .dbg_byte(dbg_b),
    .brownout_det(bdet), .power_down(pdn), .pll_lock(lock));

  cdr_config_decode_reset_seq #(.POWERUP_TIMER_STEP_CYC(STEP), .OST_CYC(OSC_STARTUP_TIMER)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .oscillator_config(osc_b),
    .watchdog_config(wdt_b), .poweron_config(por_b), .debug_config(dbg_b),
    .initial_osc_select(iosc), .brownout_det(bdet), .power_down(pdn), .pll_lock(lock),
    .soft_wr(soft_wr), .soft_wdata(soft_wdata), .bor_flag_clr(bor_flag_clr),
    .pps_cfg_write(pps_cfg_write), .cfg(cfg), .watchdog_enable(wd_en),
    .low_power_rc_enable(low_power_rc_osc_en), .watchdog_soft_enable(soft_en), .bor_flag(bor_flag),
    .bor_reset_pulse(bor_pulse), .internal_reset_n(irst_n), .exec_enable(exec_en),
    .sys_clk_hold(clk_hold), .clk_src(clk_src), .pps_write_ok(pps_ok));

  // one comparison, counted
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
  begin
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  // counts cycles until reset is released; too early is as bad as too late
  task automatic wait_rel(input int lo, input int hi, input string what);
    int n;
  begin
    n = 0;
    while (irst_n !== 1'b1 && n <= hi)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1, what);
  end
  endtask

  // new configuration, then let model and decode register it
  task automatic setc(input logic [31:0] c);
  begin
    @(posedge core_clk);
    cfg_req <= c;
    repeat (3) @(negedge core_clk);
  end
  endtask

  // one-cycle strobe: 0 soft write, 1 pin-select write, 2 flag clear
  task automatic strobe(input int kind, input logic d);
  begin
    @(posedge core_clk);
    soft_wr <= kind == 0;
    soft_wdata <= d;
    pps_cfg_write <= kind == 1;
    bor_flag_clr <= kind == 2;
    @(posedge core_clk);
    soft_wr <= 1'b0;
    pps_cfg_write <= 1'b0;
    bor_flag_clr <= 1'b0;
    @(negedge core_clk);
  end
  endtask

  // brown-out held four cycles; pulse must last one cycle only
  task automatic brownout(input logic [31:0] c, input logic lk);
    int n;
  begin
    @(posedge core_clk);
    cfg_req <= c;
    lock_en <= lk;
    iosc <= cdr_pkg::IOSC_PRI_PLL;
    bor_req <= 1'b1;
    n = 0;
    while (bor_pulse !== 1'b1 && n < 6)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(bor_pulse, 1'b1, "reset pulse");
    @(negedge core_clk);
    chk(bor_pulse, 1'b0, "pulse width");
    chk({bor_flag, irst_n, clk_hold}, 3'b101, "flag and reset");
    @(posedge core_clk);
    bor_req <= 1'b0;
  end
  endtask

  // closing verdict
  task automatic conclude();
  begin
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  // hang guard, far beyond the expected run of some 5000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    chk({cfg, irst_n, exec_en, clk_hold}, 42'h1, "in reset");
    @(posedge core_clk);
    rst_n <= 1'b1;
    wait_rel(REG + 4 * STEP, REG + 4 * STEP + 8, "power-on delay");
    chk({exec_en, clk_hold, clk_src}, 5'b10000, "running");
    $display("test power_on done");
    // decode table over every field code
    @(posedge core_clk);
    allow_rsv <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      setc({i[3:2], i[0], 2'b00, i[3], i[1:0], i[0], i[1], 1'b0, i[2], i[3:0],
        2'b00, i[0], 2'b00, i[2:0], 6'h00, i[1:0]});
      xtal = i[1:0] == 2'b01 || i[1:0] == 2'b10;
      e = '0;
      e.clk_switch_en = !i[3];
      e.fail_safe_en = i[3:2] == 2'b00;
      e.pin_select_lock_once = i[0];
      e.oscillator_out_pin_clock_out = i[3] && !xtal;
      e.oscillator_out_pin_gpio = !i[3] && !xtal;
      e.posc_disabled = i[1:0] == 2'b11;
      e.posc_hs = i[1:0] == 2'b10;
      e.posc_xt = i[1:0] == 2'b01;
      e.posc_ec = i[1:0] == 2'b00;
      e.wdt_window_en = !i[1];
      e.wdt_prescale_div = i[2] ? cdr_pkg::WDT_PRE_128 : cdr_pkg::WDT_PRE_32;
      e.wdt_postscale_div = 16'h0001 << i[3:0];
      e.i2c_primary = i[0];
      e.i2c_alternate = !i[0];
      e.debug_pair = i[1:0] == 2'b11 ? 3'h1 : i[1:0] == 2'b10 ? 3'h2 :
        i[1:0] == 2'b01 ? 3'h4 : 3'h0;
      chk(cfg, e, "decode");
    end
    @(posedge core_clk);
    allow_rsv <= 1'b0;
    $display("test decode done");
    // fuse on: clearing the soft bit does nothing
    setc(32'hc0800003);
    strobe(0, 1'b1);
    strobe(0, 1'b0);
    chk({soft_en, wd_en, low_power_rc_osc_en}, 3'b111, "fuse keeps watchdog");
    setc(32'hc0000003);
    chk({wd_en, low_power_rc_osc_en}, 2'b11, "soft bit on");
    strobe(0, 1'b0);
    chk({soft_en, wd_en, low_power_rc_osc_en}, 3'b000, "soft bit off");
    strobe(0, 1'b1);
    chk(wd_en, 1'b1, "soft bit on again");
    $display("test watchdog done");
    // lock once: first write allowed, later ones refused
    setc(32'he0000003);
    chk(pps_ok, 1'b1, "first pin write open");
    strobe(1, 1'b0);
    chk(pps_ok, 1'b0, "locked after one");
    strobe(1, 1'b0);
    chk(pps_ok, 1'b0, "still locked");
    $display("test pin_lock_once done");
    // resume after power-down repeats regulator start-up, no flag
    setc(32'hc0000103);
    @(posedge core_clk);
    iosc <= 3'h0;
    pd_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    pd_req <= 1'b0;
    wait_rel(REG + STEP, REG + STEP + 8, "resume delay");
    chk({bor_flag, soft_en}, 2'b00, "no flag, soft bit cleared");
    strobe(1, 1'b0);
    strobe(1, 1'b0);
    chk(pps_ok, 1'b1, "repeated pin writes");
    $display("test power_down done");
    // crystal with timer off: fixed fallback delay, pll already locked
    brownout(32'hc1000003, 1'b1);
    wait_rel(REG + FS, REG + FS + 8, "crystal fallback");
    chk(clk_src, cdr_pkg::IOSC_PRI_PLL, "clock source");
    $display("test brownout_crystal done");
    // pll not locked: clock stays held past every other delay
    brownout(32'hc1000103, 1'b0);
    repeat (REG + STEP + OSC_STARTUP_TIMER + 40) @(negedge core_clk);
    chk({irst_n, clk_hold}, 2'b01, "held for lock");
    @(posedge core_clk);
    lock_en <= 1'b1;
    wait_rel(LOCK, LOCK + 8, "release on lock");
    strobe(2, 1'b0);
    chk(bor_flag, 1'b0, "flag cleared");
    $display("test brownout_pll done");
    conclude();
  end
endmodule // test_config_decode_reset_seq
